// *** src/sfc_cmd_read.v ***
// Serial flash command front end: framing, opcode decode, array read.
// Assumes an array read port on core_clk that answers one cycle after
// each read strobe, and a host that keeps the serial clock well below
// a quarter of core_clk.
//
// Contract
// - Select low, opcode, then address and data
// - All bytes travel most significant bit first
// - Unknown opcode ignored until next select
// - Early deselect performs nothing, returns idle
// - Three address bytes, upper bits ignored
// - Read address counter auto-increments
// - Fast read has one dummy byte
// - Array end wraps to zero, no gap
// - Deselect ends single read, floats output
// - Decode page and block erase opcodes
// - Decode three whole-array erase opcodes
// - Decode program with address and data
// - Decode write enable and disable
// - Decode OTP program and OTP read
// - Decode status read and status writes
// - Reset valid only with D0h confirmation
// - Decode both identification opcodes
// - Decode the three power opcodes
// - Dual read: opcode, address, one dummy
// - Dual read emits two bits per clock
// - Deselect ends dual read, floats both lines
// - Sample on rising, drive on falling edge
// - Output floats whenever not selected
// - Input line turns around in dual read
`timescale 1ns/1ps
`include "sfc_defs.vh"

module sfc_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         flush,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module sfc_cmd_read #(
  parameter AW     = `SFC_ARR_AW,
  parameter FIFO_D = `SFC_FIFO_D
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          cs_n,
  input  wire          sck,
  input  wire          second_data_line_in,
  output reg           second_data_line_out_q,
  output reg           second_data_line_oe_q,
  output reg           so_out_q,
  output reg           so_oe_q,
  output reg  [AW-1:0] arr_addr_q,
  output reg           arr_rd_q,
  input  wire [7:0]    arr_rdata,
  output reg           cmd_valid_q,
  output reg  [7:0]    cmd_op_q,
  output reg  [23:0]   cmd_addr_q,
  output reg  [7:0]    rx_byte_q,
  output reg           rx_stb_q
);
  localparam ST_OPC = `SFC_ST_OPC;
  localparam ST_ADR = `SFC_ST_ADR;
  localparam ST_DUM = `SFC_ST_DUM;
  localparam ST_RXD = `SFC_ST_RXD;
  localparam ST_TXD = `SFC_ST_TXD;
  localparam ST_IGN = `SFC_ST_IGN;

  // Supported opcode table
  function is_known;
    input [7:0] op;
    begin
      case (op)
        `SFC_OP_READ_FAST, `SFC_OP_READ_SLOW, `SFC_OP_READ_DUAL,
        `SFC_OP_PG_ERASE, `SFC_OP_BLK4_ERASE, `SFC_OP_BLK32_A,
        `SFC_OP_BLK32_B, `SFC_OP_CHIP_A, `SFC_OP_CHIP_B,
        `SFC_OP_CHIP_OLD, `SFC_OP_PROGRAM, `SFC_OP_WR_EN,
        `SFC_OP_WR_DIS, `SFC_OP_OTP_PROG, `SFC_OP_OTP_READ,
        `SFC_OP_STAT_RD, `SFC_OP_STAT_WR1, `SFC_OP_STAT_WR2,
        `SFC_OP_SW_RESET, `SFC_OP_ID, `SFC_OP_ID_OLD,
        `SFC_OP_DEEP_SLEEP, `SFC_OP_WAKE, `SFC_OP_ULTRA_SLP:
          is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  // Opcodes followed by three address bytes
  function has_addr;
    input [7:0] op;
    begin
      case (op)
        `SFC_OP_READ_FAST, `SFC_OP_READ_SLOW, `SFC_OP_READ_DUAL,
        `SFC_OP_PG_ERASE, `SFC_OP_BLK4_ERASE, `SFC_OP_BLK32_A,
        `SFC_OP_BLK32_B, `SFC_OP_PROGRAM, `SFC_OP_OTP_PROG,
        `SFC_OP_OTP_READ:
          has_addr = 1'b1;
        default: has_addr = 1'b0;
      endcase
    end
  endfunction

  // Dummy bytes after the address
  function [1:0] dummies;
    input [7:0] op;
    begin
      case (op)
        `SFC_OP_READ_FAST: dummies = 2'h1;
        `SFC_OP_READ_DUAL: dummies = 2'h1;
        `SFC_OP_OTP_READ:  dummies = 2'h2;
        default:           dummies = 2'h0;
      endcase
    end
  endfunction

  // Array reads served from this block
  function is_arr_read;
    input [7:0] op;
    begin
      is_arr_read = (op == `SFC_OP_READ_FAST) ||
                    (op == `SFC_OP_READ_SLOW) ||
                    (op == `SFC_OP_READ_DUAL);
    end
  endfunction

  // Synchronisers; the first stages feed nothing but the second
  reg        cs_s1_q;
  reg        cs_s2_q;
  reg        cs_s3_q;
  reg        sck_s1_q;
  reg        sck_s2_q;
  reg        sck_s3_q;
  reg        si_s1_q;
  reg        si_s2_q;

  reg [5:0]  state_q;
  reg [2:0]  bit_cnt_q;
  reg [1:0]  byte_cnt_q;
  reg [1:0]  data_cnt_q;
  reg [6:0]  sh_in_q;
  reg [7:0]  first_data_q;
  reg        hdr_ok_q;
  reg        dual_q;
  reg [2:0]  tx_cnt_q;
  reg [7:0]  sh_out_q;
  reg        pf_en_q;
  reg        pend_q;

  wire       sel;
  wire       desel_edge;
  wire       rise;
  wire       fall;
  wire [7:0] in_byte;
  wire       byte_done;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       fifo_pop;
  wire       cmd_ok;

  assign sel        = ~cs_s2_q;
  // Edge taken behind the second stage; the first stage may be metastable
  assign desel_edge = cs_s2_q & ~cs_s3_q;
  assign rise       = sel & sck_s2_q & ~sck_s3_q;
  assign fall       = sel & ~sck_s2_q & sck_s3_q;
  assign in_byte    = {sh_in_q, si_s2_q};
  assign byte_done  = rise && (bit_cnt_q == 3'h7);
  assign fifo_pop   = fall && (state_q == ST_TXD) && (tx_cnt_q == 3'h0);

  // Completion test applied at deselect; partial bytes abort
  assign cmd_ok = hdr_ok_q && (bit_cnt_q == 3'h0) &&
    (((cmd_op_q != `SFC_OP_PROGRAM) &&
      (cmd_op_q != `SFC_OP_OTP_PROG)) ||
     (data_cnt_q != 2'h0)) &&
    (((cmd_op_q != `SFC_OP_STAT_WR1) &&
      (cmd_op_q != `SFC_OP_STAT_WR2)) ||
     (data_cnt_q == 2'h1)) &&
    ((cmd_op_q != `SFC_OP_SW_RESET) ||
     ((data_cnt_q == 2'h1) &&
      (first_data_q == `SFC_RESET_CONFIRM)));

  always @(posedge core_clk) begin
    if (rst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q  <= 1'b0;
      si_s2_q  <= 1'b0;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= second_data_line_in;
      si_s2_q  <= si_s1_q;
    end
  end

  // Framing: every deselected cycle returns to opcode phase
  always @(posedge core_clk) begin
    if (rst) begin
      state_q      <= ST_OPC;
      bit_cnt_q    <= 3'h0;
      byte_cnt_q   <= 2'h0;
      data_cnt_q   <= 2'h0;
      sh_in_q      <= 7'h00;
      first_data_q <= 8'h00;
      hdr_ok_q     <= 1'b0;
      dual_q       <= 1'b0;
      cmd_op_q     <= 8'h00;
      cmd_addr_q   <= 24'h000000;
      cmd_valid_q  <= 1'b0;
      rx_byte_q    <= 8'h00;
      rx_stb_q     <= 1'b0;
      pf_en_q      <= 1'b0;
    end else begin
      cmd_valid_q <= desel_edge && cmd_ok;
      rx_stb_q    <= 1'b0;
      if (!sel) begin
        state_q    <= ST_OPC;
        bit_cnt_q  <= 3'h0;
        byte_cnt_q <= 2'h0;
        data_cnt_q <= 2'h0;
        hdr_ok_q   <= 1'b0;
        dual_q     <= 1'b0;
        pf_en_q    <= 1'b0;
      end else if (rise && (state_q != ST_TXD)) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        sh_in_q   <= in_byte[6:0];
        if (byte_done) begin
          case (state_q)
            ST_OPC: begin
              cmd_op_q   <= in_byte;
              byte_cnt_q <= 2'h0;
              if (!is_known(in_byte)) begin
                state_q <= ST_IGN;
              end else if (has_addr(in_byte)) begin
                state_q <= ST_ADR;
              end else begin
                hdr_ok_q <= 1'b1;
                state_q  <= ST_RXD;
              end
            end
            ST_ADR: begin
              cmd_addr_q <= {cmd_addr_q[15:0], in_byte};
              byte_cnt_q <= byte_cnt_q + 2'h1;
              if (byte_cnt_q == `SFC_ADDR_BYTES - 2'h1) begin
                hdr_ok_q   <= 1'b1;
                byte_cnt_q <= 2'h0;
                dual_q     <= (cmd_op_q == `SFC_OP_READ_DUAL);
                pf_en_q    <= is_arr_read(cmd_op_q);
                if (dummies(cmd_op_q) != 2'h0) begin
                  state_q <= ST_DUM;
                end else if (is_arr_read(cmd_op_q)) begin
                  state_q <= ST_TXD;
                end else begin
                  state_q <= ST_RXD;
                end
              end
            end
            ST_DUM: begin
              byte_cnt_q <= byte_cnt_q + 2'h1;
              if (byte_cnt_q == dummies(cmd_op_q) - 2'h1) begin
                state_q <= is_arr_read(cmd_op_q) ? ST_TXD : ST_RXD;
              end
            end
            ST_RXD: begin
              rx_byte_q <= in_byte;
              rx_stb_q  <= 1'b1;
              if (data_cnt_q == 2'h0) begin
                first_data_q <= in_byte;
              end
              if (data_cnt_q != 2'h3) begin
                data_cnt_q <= data_cnt_q + 2'h1;
              end
            end
            default: begin
              state_q <= state_q;
            end
          endcase
        end
      end
    end
  end

  // Prefetch: one read in flight, stalled by the FIFO's ready.
  // The counter is as wide as the array, so it wraps with no gap.
  always @(posedge core_clk) begin
    if (rst) begin
      arr_addr_q <= {AW{1'b0}};
      arr_rd_q   <= 1'b0;
      pend_q     <= 1'b0;
    end else begin
      pend_q   <= arr_rd_q && sel;
      arr_rd_q <= 1'b0;
      if (!sel) begin
        arr_rd_q <= 1'b0;
      end else if (rise && (state_q == ST_ADR) &&
                   (byte_cnt_q == `SFC_ADDR_BYTES - 2'h1) &&
                   (bit_cnt_q == 3'h7)) begin
        arr_addr_q <= {cmd_addr_q[AW-9:0], in_byte};
      end else if (pf_en_q && fifo_in_ready && !arr_rd_q && !pend_q) begin
        arr_rd_q <= 1'b1;
      end
      if (arr_rd_q) begin
        arr_addr_q <= arr_addr_q + 1'b1;
      end
    end
  end

  sfc_fifo #(
    .W  (`SFC_FIFO_W),
    .D  (FIFO_D),
    .AW (4)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .flush     (~sel),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (arr_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Output shifter; new bits only on falling edges of the serial clock
  always @(posedge core_clk) begin
    if (rst) begin
      so_out_q               <= 1'b0;
      so_oe_q                <= 1'b0;
      second_data_line_out_q <= 1'b0;
      second_data_line_oe_q  <= 1'b0;
      tx_cnt_q               <= 3'h0;
      sh_out_q               <= 8'h00;
    end else if (!sel) begin
      so_oe_q               <= 1'b0;
      second_data_line_oe_q <= 1'b0;
      tx_cnt_q              <= 3'h0;
    end else if (fall && (state_q == ST_TXD)) begin
      so_oe_q               <= 1'b1;
      second_data_line_oe_q <= dual_q;
      if (tx_cnt_q == 3'h0) begin
        // An empty FIFO here means the host clock outran the prefetch
        so_out_q <= fifo_out_data[7];
        if (dual_q) begin
          second_data_line_out_q <= fifo_out_data[6];
          sh_out_q               <= {fifo_out_data[5:0], 2'b00};
          tx_cnt_q               <= 3'h3;
        end else begin
          sh_out_q <= {fifo_out_data[6:0], 1'b0};
          tx_cnt_q <= 3'h7;
        end
      end else begin
        so_out_q <= sh_out_q[7];
        tx_cnt_q <= tx_cnt_q - 3'h1;
        if (dual_q) begin
          second_data_line_out_q <= sh_out_q[6];
          sh_out_q               <= {sh_out_q[5:0], 2'b00};
        end else begin
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// *** common/sfc_defs.vh ***
// Constants for the serial flash command front end.
// Assumes inclusion by the design file only; definitions, no logic.
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// Opcodes
`define SFC_OP_READ_FAST  8'h0B
`define SFC_OP_READ_SLOW  8'h03
`define SFC_OP_READ_DUAL  8'h3B
`define SFC_OP_PG_ERASE   8'h81
`define SFC_OP_BLK4_ERASE 8'h20
`define SFC_OP_BLK32_A    8'h52
`define SFC_OP_BLK32_B    8'hD8
`define SFC_OP_CHIP_A     8'h60
`define SFC_OP_CHIP_B     8'hC7
`define SFC_OP_CHIP_OLD   8'h62
`define SFC_OP_PROGRAM    8'h02
`define SFC_OP_WR_EN      8'h06
`define SFC_OP_WR_DIS     8'h04
`define SFC_OP_OTP_PROG   8'h9B
`define SFC_OP_OTP_READ   8'h77
`define SFC_OP_STAT_RD    8'h05
`define SFC_OP_STAT_WR1   8'h01
`define SFC_OP_STAT_WR2   8'h31
`define SFC_OP_SW_RESET   8'hF0
`define SFC_RESET_CONFIRM 8'hD0
`define SFC_OP_ID         8'h9F
`define SFC_OP_ID_OLD     8'h15
`define SFC_OP_DEEP_SLEEP 8'hB9
`define SFC_OP_WAKE       8'hAB
`define SFC_OP_ULTRA_SLP  8'h79

// Framing
`define SFC_ADDR_BYTES    2'h3
`define SFC_ARR_AW        15
`define SFC_ARR_LAST      15'h7FFF
`define SFC_FIFO_W        8
`define SFC_FIFO_D        16

// One-hot framing states
`define SFC_ST_OPC        6'h01
`define SFC_ST_ADR        6'h02
`define SFC_ST_DUM        6'h04
`define SFC_ST_RXD        6'h08
`define SFC_ST_TXD        6'h10
`define SFC_ST_IGN        6'h20

`endif

// *** testbench/sfc_cmd_read_asserts.sv ***
// Checker for the serial flash command front end.
// Assumes a bind to sfc_cmd_read; sees only that module's ports.
`timescale 1ns/1ps
module sfc_cmd_read_asserts #(
  parameter AW = 15
) (
  input wire          core_clk,
  input wire          rst,
  input wire          cs_n,
  input wire          sck,
  input wire          second_data_line_in,
  input wire          second_data_line_out_q,
  input wire          second_data_line_oe_q,
  input wire          so_out_q,
  input wire          so_oe_q,
  input wire [AW-1:0] arr_addr_q,
  input wire          arr_rd_q,
  input wire [7:0]    arr_rdata,
  input wire          cmd_valid_q,
  input wire [7:0]    cmd_op_q,
  input wire [23:0]   cmd_addr_q,
  input wire [7:0]    rx_byte_q,
  input wire          rx_stb_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Strobes are at least three cycles apart: one read in flight at most
  sequence s_two_reads;
    arr_rd_q ##3 arr_rd_q;
  endsequence
  sequence s_wrap_reads;
    arr_rd_q && (&arr_addr_q) ##3 arr_rd_q;
  endsequence
  // Select sync takes two cycles and the enable clear one more, so four idle samples are just enough
  a_float_idle: assert property (
    cs_n [*4] |-> !so_oe_q && !second_data_line_oe_q)
    else $error("output enabled while deselected");
  a_addr_advance: assert property (
    s_two_reads |-> arr_addr_q == $past(arr_addr_q, 3) + 1'b1)
    else $error("read address did not advance by one");
  a_addr_wrap: assert property (
    s_wrap_reads |-> arr_addr_q == '0)
    else $error("read address did not wrap to zero");
  a_strobe_pulse: assert property (
    arr_rd_q |=> !arr_rd_q)
    else $error("read strobe longer than one cycle");
  a_valid_pulse: assert property (
    cmd_valid_q |=> !cmd_valid_q)
    else $error("command pulse longer than one cycle");
  a_valid_deselect: assert property (
    cmd_valid_q |-> cs_n && $past(cs_n))
    else $error("command pulse without deselect");
  a_rx_pulse: assert property (
    rx_stb_q |=> !rx_stb_q)
    else $error("data strobe longer than one cycle");
  a_dual_only: assert property (
    second_data_line_oe_q |-> so_oe_q && cmd_op_q == 8'h3B)
    else $error("second line driven outside dual read");
  a_enable_read: assert property (
    $rose(so_oe_q) |-> !cs_n && cmd_op_q inside {8'h0B, 8'h03, 8'h3B})
    else $error("output enabled outside a read");
  a_out_stable: assert property (
    (sck && !cs_n) [*4] |-> $stable(so_out_q)
      && $stable(second_data_line_out_q))
    else $error("output changed while clock high");
endmodule

bind sfc_cmd_read sfc_cmd_read_asserts #(.AW(AW)) i_chk (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
  .second_data_line_in(second_data_line_in),
  .second_data_line_out_q(second_data_line_out_q),
  .second_data_line_oe_q(second_data_line_oe_q),
  .so_out_q(so_out_q), .so_oe_q(so_oe_q), .arr_addr_q(arr_addr_q),
  .arr_rd_q(arr_rd_q), .arr_rdata(arr_rdata), .cmd_valid_q(cmd_valid_q),
  .cmd_op_q(cmd_op_q), .cmd_addr_q(cmd_addr_q), .rx_byte_q(rx_byte_q),
  .rx_stb_q(rx_stb_q));

// *** testbench/sfc_host.sv ***
// Host model: drives select, serial clock and the shared data line.
// Assumes core_clk is the bench clock; each low clock phase is 4 cycles, each high phase 5.
`timescale 1ns/1ps
module sfc_host (
  input  wire core_clk,
  output reg  cs_n,
  output reg  sck,
  output wire sdl,
  input  wire so_out,
  input  wire so_oe,
  input  wire sdl_out,
  input  wire sdl_oe
);
  reg  mosi;
  reg  drv;
  reg  junk;
  wire so_w;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    drv = 1'b1;
    junk = 1'b0;
  end
  always @(posedge core_clk) junk <= ~junk;
  // Released lines toggle, so a stale bit never reads as data
  assign sdl = sdl_oe ? sdl_out : (drv && !cs_n) ? mosi : junk;
  assign so_w = so_oe ? so_out : junk;
  task start(input bit m3);
    @(posedge core_clk);
    sck <= m3;
    drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // Data set on the falling edge, output taken just before the next one
  task xfer(input [7:0] tx, input int nb, input bit dual,
            output [7:0] rx);
    int i;
    for (i = 0; i < nb; i++) begin
      @(posedge core_clk);
      sck <= 1'b0;
      mosi <= tx[7-i];
      drv <= !dual;
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      rx = dual ? {rx[5:0], so_w, sdl} : {rx[6:0], so_w};
    end
  endtask
  task stop;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask
endmodule

// *** testbench/test_serial_flash_command_read.sv ***
// Bench for the serial flash command front end.
// Assumes the host model and the bound checker compile beforehand.
`timescale 1ns/1ps
module test_serial_flash_command_read;
  reg         core_clk, rst;
  reg  [7:0]  arr_rdata, rx;
  reg  [15:0] seed;
  int         num_errors, n_tests, n_val, n_rx;
  wire        cs_n, sck, sdl, sdl_out, sdl_oe, so_out, so_oe;
  wire        arr_rd, cmd_valid, rx_stb;
  wire [14:0] arr_addr;
  wire [7:0]  cmd_op, rx_byte;
  wire [23:0] cmd_addr;
  // Fields: opcode, header bytes, data bytes, accepted, data value
  localparam logic [31:0] TBL [0:25] = '{
    32'h81300100, 32'h20300100, 32'h52300100, 32'hD8300100,
    32'h60000100, 32'hC7000100, 32'h62000100,
    32'h023201A5, 32'h023000FF,
    32'h06000100, 32'h04000100, 32'h9B31013C, 32'h77500100,
    32'h05000100, 32'h0101015A, 32'h31010181, 32'h010200C3,
    32'hF00101D0, 32'hF0010055, 32'h9F000100, 32'h15000100,
    32'hB9000100, 32'hAB000100, 32'h79000100,
    32'h81100000, 32'h5A030006};
  sfc_host i_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck),
    .sdl(sdl), .so_out(so_out), .so_oe(so_oe), .sdl_out(sdl_out),
    .sdl_oe(sdl_oe));
  sfc_cmd_read #(.AW(15), .FIFO_D(16)) i_dut (.core_clk(core_clk),
    .rst(rst), .cs_n(cs_n), .sck(sck), .second_data_line_in(sdl),
    .second_data_line_out_q(sdl_out), .second_data_line_oe_q(sdl_oe),
    .so_out_q(so_out), .so_oe_q(so_oe), .arr_addr_q(arr_addr),
    .arr_rd_q(arr_rd), .arr_rdata(arr_rdata), .cmd_valid_q(cmd_valid),
    .cmd_op_q(cmd_op), .cmd_addr_q(cmd_addr), .rx_byte_q(rx_byte),
    .rx_stb_q(rx_stb));
  function [15:0] step(input [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [7:0] mem_of(input [14:0] a);
    mem_of = a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
  endfunction
  // Array answers one cycle after a strobe; otherwise it shows garbage
  always @(posedge core_clk) begin
    arr_rdata <= arr_rd ? mem_of(arr_addr) : ~arr_rdata;
    n_val <= n_val + cmd_valid;
    n_rx <= n_rx + rx_stb;
  end
  task check(input string what, input [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task rd(input [7:0] op, input [23:0] a, input int n, input bit m3);
    int k;
    bit d;
    d = (op == 8'h3B);
    i_host.start(m3);
    i_host.xfer(op, 8, 0, rx);
    for (k = 2; k >= 0; k--) i_host.xfer(a[k*8 +: 8], 8, 0, rx);
    if (op != 8'h03) i_host.xfer(8'h00, 8, 0, rx);
    for (k = 0; k < n; k++) begin
      i_host.xfer(8'hFF, d ? 4 : 8, d, rx);
      check("read byte", rx, mem_of(a[14:0] + k));
    end
    i_host.xfer(8'hFF, 3, d, rx);
    i_host.stop;
    check("output enables", {so_oe, sdl_oe}, 2'b00);
  endtask
  task cmd(input [31:0] e);
    int k, v0, r0;
    reg [23:0] a;
    v0 = n_val;
    r0 = n_rx;
    i_host.start(0);
    i_host.xfer(e[31:24], 8, 0, rx);
    for (k = 0; k < e[23:20]; k++) begin
      seed = step(seed);
      a = {a[15:0], seed[7:0]};
      i_host.xfer(seed[7:0], 8, 0, rx);
    end
    for (k = 0; k < e[19:16]; k++) i_host.xfer(e[7:0], 8, 0, rx);
    i_host.stop;
    check("command taken", n_val - v0, e[8]);
    if (e[8]) check("opcode", cmd_op, e[31:24]);
    if (e[23:20] == 3) check("address", cmd_addr, a);
    check("data count", n_rx - r0, e[31:24] == 8'h5A ? 0 : e[19:16]);
    if (e[19:16] > 0 && e[31:24] != 8'h5A)
      check("data byte", rx_byte, e[7:0]);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #3000000;
    num_errors++;
    summarize;
  end
  initial begin
    int k;
    reg [23:0] ra;
    rst = 1'b1;
    arr_rdata = 8'h00;
    seed = 16'h0032;
    num_errors = 0;
    n_tests = 0;
    n_val = 0;
    n_rx = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (k = 0; k < 26; k++) cmd(TBL[k]);
    for (k = 0; k < 3; k++) begin
      seed = step(seed);
      ra[15:0] = seed;
      seed = step(seed);
      ra[23:16] = seed[7:0];
      rd(k == 2 ? 8'h3B : 8'h0B, ra, 3, 0);
    end
    rd(8'h03, 24'hFF7FFE, 3, 1);
    rd(8'h3B, 24'h807FFF, 2, 0);
    summarize;
  end
endmodule
